/* File: logic/cbi_bus_if.sv */
// What this block does
// - 32-bit address, data width strapped at reset
// - 32-bit bus: 1 to 4 byte transfers
// - 32-bit bus: single, two or eight beats
// - 32-bit bus: line moves in eight beats
// - 32-bit bus: noncached uses one or two beats
// - 64-bit bus: 1 to 8 byte transfers
// - 64-bit bus: single beat or four-beat line
// - 64-bit bus: noncached accesses single beat
// - address-only and address-plus-data transactions
// - address tenure starts only after the earlier data tenure has ended
// - address and data buses granted separately
// - request each bus, arbiter grants it
// - start strobe marks new address tenure
// - four address parity bits, parity error flag
// - drive type code, size, burst, wt, ci
// - data parity per lane, error flag
// - active-low pins asserted when low
// - bus period integer multiple of clock
// - processor state outputs and controls
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cbi_map.svh"

module cbi_bus_if
  import cbi_pkg::*;
#(
  parameter bit ODD_PAR = 1'b1
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // configuration strap and processor state
  input  wire logic        width64_i,
  input  wire logic        qack_n_i,
  input  wire logic        tlbsync_n_i,
  output logic             rsrv_o,
  output logic             tben_o,
  output logic             qreq_n_o,
  output logic             bus_sync_o,
  // address tenure
  output logic             br_n_o,
  input  wire logic        bg_n_i,
  output logic             transfer_start_strobe_n_o,
  output logic      [31:0] addr_o,
  output logic             addr_oe_o,
  output logic      [3:0]  address_parity_bits_o,
  output logic      [4:0]  transfer_type_code_o,
  output logic      [2:0]  tsiz_o,
  output logic             tbst_n_o,
  output logic             wt_n_o,
  output logic             ci_n_o,
  input  wire logic        aack_n_i,
  input  wire logic        address_retry_n_i,
  input  wire logic        aperr_n_i,
  // data tenure
  output logic             dbr_n_o,
  input  wire logic        dbg_n_i,
  input  wire logic [63:0] data_i,
  output logic      [63:0] data_o,
  output logic             data_oe_o,
  input  wire logic [7:0]  dp_i,
  output logic      [7:0]  dp_o,
  output logic             dperr_n_o,
  input  wire logic        ta_n_i,
  input  wire logic        drtry_n_i
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  localparam int SW = 82;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  wire  [SW-1:0] in_raw = {width64_i, bg_n_i, aack_n_i, address_retry_n_i, dbg_n_i, ta_n_i,
                           drtry_n_i, aperr_n_i, qack_n_i, tlbsync_n_i, dp_i, data_i};

  // data only; the aperr flag and the status bits read them from reset on, the sequencer only after the strap wait
  always_ff @(posedge clk_i)
  begin
    sync1_q <= in_raw;
    sync2_q <= sync1_q;
  end

  wire [63:0] din_s     = sync2_q[63:0];
  wire [7:0]  dp_s      = sync2_q[71:64];
  wire        hold_n_s  = sync2_q[72];
  wire        qack_n_s  = sync2_q[73];
  wire        aperr_n_s = sync2_q[74];
  wire        drtry_n_s = sync2_q[75];
  wire        ta_n_s    = sync2_q[76];
  wire        dbg_n_s   = sync2_q[77];
  wire        address_retry_n_s = sync2_q[78];
  wire        aack_n_s  = sync2_q[79];
  wire        bg_n_s    = sync2_q[80];
  wire        width_s   = sync2_q[81];

  // --------------------------------------------------------------------------
  // registers and wishbone decode
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] addr_reg_q;
  logic [31:0] cmd_q;
  logic [31:0] data_q [`CBI_DATA_WORDS];
  logic        go_q;
  logic        done_q;
  logic        aperr_q;
  logic        dperr_q;
  logic        bus64_q;
  logic [1:0]  strap_cnt_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  cbi_state_t  st_q;
  cbi_state_t  st_d;
  logic [2:0]  beat_q;
  logic [2:0]  beat_d;

  function automatic logic [31:0] cbi_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[8*i +: 8] = n[8*i +: 8];
    return r;
  endfunction : cbi_merge

  wire        strap_ok  = (strap_cnt_q == 2'h3);
  wire        busy_w    = go_q | (st_q != CBI_S_IDLE) | !strap_ok;
  wire        acc_w     = wb_cyc_i & wb_stb_i;
  wire        wr_w      = acc_w & wb_we_i & ack_q;
  wire        sel_ctrl  = (wb_adr_i == `CBI_OFF_CTRL);
  wire        sel_addr  = (wb_adr_i == `CBI_OFF_ADDR);
  wire        sel_cmd   = (wb_adr_i == `CBI_OFF_CMD);
  wire        sel_stat  = (wb_adr_i == `CBI_OFF_STAT);
  wire        sel_data  = (wb_adr_i[7:5] == `CBI_DATA_PAGE);
  wire        wr_ctrl   = wr_w & sel_ctrl;
  // address and command are frozen while a transaction is in flight
  wire        wr_addr   = wr_w & sel_addr & !busy_w;
  wire        wr_cmd    = wr_w & sel_cmd & wb_sel_i[0] & !busy_w;
  wire        wr_stat   = wr_w & sel_stat & wb_sel_i[0];
  wire        wr_data   = wr_w & sel_data;
  wire [31:0] stat_w    = {25'h0, !hold_n_s, !qack_n_s, bus64_q, dperr_q, aperr_q, done_q, busy_w};
  wire [31:0] rd_w      = sel_ctrl ? ctrl_q :
                          sel_addr ? addr_reg_q :
                          sel_cmd  ? cmd_q :
                          sel_stat ? stat_w :
                          sel_data ? data_q[wb_adr_i[4:2]] : 32'h0;

  // ack one cycle after the request; a write lands on the ack edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end
    else
    begin
      ack_q  <= acc_w & !ack_q;
      rdat_q <= rd_w;
    end
  end

  // --------------------------------------------------------------------------
  // bus clock divider
  // --------------------------------------------------------------------------
  logic [3:0] div_q;
  wire  [3:0] ratio_w  = ctrl_q[`CBI_CTRL_RATIO_MSB:`CBI_CTRL_RATIO_LSB];
  wire  [3:0] ratio_m1 = (ratio_w == 4'h0) ? 4'h0 : ratio_w - 4'h1;
  // the bus only moves on a tick; lowering the ratio mid-transfer ends the current period at the new length, or at once if it is already that long
  wire        tick_w   = (div_q >= ratio_m1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_q <= 4'h0;
    else
      div_q <= tick_w ? 4'h0 : div_q + 4'h1;
  end

  // --------------------------------------------------------------------------
  // transaction decode
  // --------------------------------------------------------------------------
  wire cbi_kind_t kind_w   = cbi_kind_t'(cmd_q[`CBI_CMD_KIND_MSB:`CBI_CMD_KIND_LSB]);
  wire            is_line  = (kind_w == CBI_K_LRD) | (kind_w == CBI_K_LWR);
  wire            is_dbl   = (kind_w == CBI_K_DRD) | (kind_w == CBI_K_DWR);
  wire            is_wr    = (kind_w == CBI_K_SWR) | (kind_w == CBI_K_DWR) | (kind_w == CBI_K_LWR);
  wire            addr_only = (kind_w == CBI_K_ADDR) | (kind_w == CBI_K_RSVD);
  // double beats exist only on the narrow bus; on the wide bus they fold into one beat
  wire [3:0]      nb_w     = is_line ? (bus64_q ? `CBI_BEATS_LINE64 : `CBI_BEATS_LINE32) :
                             (is_dbl & !bus64_q) ? `CBI_BEATS_DBL32 : `CBI_BEATS_SINGLE;
  wire [2:0]      sz_raw   = cmd_q[`CBI_CMD_SIZE_MSB:`CBI_CMD_SIZE_LSB];
  // size 0 means eight bytes; the narrow bus caps at four
  wire [2:0]      sz_w     = (!bus64_q & ((sz_raw == 3'h0) | (sz_raw > `CBI_MAX_BYTES32))) ?
                             `CBI_MAX_BYTES32 : sz_raw;
  wire            last_w   = ({1'b0, beat_q} == nb_w - 4'h1);
  wire [2:0]      idx_lo   = bus64_q ? {beat_d[1:0], 1'b0} : beat_d;
  wire [2:0]      idx_hi   = {beat_d[1:0], 1'b1};
  wire [63:0]     dout_w   = bus64_q ? {data_q[idx_hi], data_q[idx_lo]} : {32'h0, data_q[idx_lo]};
  wire            beat_ok  = tick_w & (st_q == CBI_S_DBEAT) & drtry_n_s & !ta_n_s;
  wire            ev_done  = (tick_w & (st_q == CBI_S_AWAIT) & address_retry_n_s & !aack_n_s & addr_only) |
                             (beat_ok & last_w);

  // --------------------------------------------------------------------------
  // parity
  // --------------------------------------------------------------------------
  cbi_par_if #(.NB(4)) apar_if ();
  cbi_par_if #(.NB(8)) opar_if ();
  cbi_par_if #(.NB(8)) ipar_if ();
  assign apar_if.data = addr_reg_q;
  assign opar_if.data = dout_w;
  assign ipar_if.data = din_s;

  cbi_par_gen #(.NB(4), .ODD(ODD_PAR)) u_apar (.p(apar_if));
  cbi_par_gen #(.NB(8), .ODD(ODD_PAR)) u_opar (.p(opar_if));
  cbi_par_gen #(.NB(8), .ODD(ODD_PAR)) u_ipar (.p(ipar_if));

  wire [7:0] lanes_w = bus64_q ? 8'hff : 8'h0f;
  wire       dbad_w  = beat_ok & !is_wr & (|((ipar_if.par ^ dp_s) & lanes_w));

  // --------------------------------------------------------------------------
  // tenure sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_d   = st_q;
    beat_d = beat_q;
    if (tick_w)
    begin
      unique case (st_q)
        CBI_S_IDLE:
          if (go_q & hold_n_s)
            st_d = CBI_S_AREQ;
        CBI_S_AREQ:
          if (!bg_n_s)
            st_d = CBI_S_ATS;
        CBI_S_ATS:
          st_d = CBI_S_AWAIT;
        CBI_S_AWAIT:
          if (!address_retry_n_s)
            st_d = CBI_S_AREQ;
          else if (!aack_n_s)
            st_d = addr_only ? CBI_S_IDLE : CBI_S_DREQ;
        CBI_S_DREQ:
          if (!dbg_n_s)
          begin
            st_d   = CBI_S_DBEAT;
            beat_d = 3'h0;
          end
        CBI_S_DBEAT:
          if (beat_ok)
          begin
            if (last_w)
              st_d = CBI_S_IDLE;
            else
              beat_d = beat_q + 3'h1;
          end
        default:
          st_d = CBI_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q   <= CBI_S_IDLE;
      beat_q <= 3'h0;
    end
    else
    begin
      st_q   <= st_d;
      beat_q <= beat_d;
    end
  end

  // --------------------------------------------------------------------------
  // control, status and data storage
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q      <= `CBI_CTRL_RST;
      addr_reg_q  <= 32'h0;
      cmd_q       <= 32'h0;
      go_q        <= 1'b0;
      done_q      <= 1'b0;
      aperr_q     <= 1'b0;
      dperr_q     <= 1'b0;
      bus64_q     <= 1'b0;
      strap_cnt_q <= 2'h0;
    end
    else
    begin
      if (!strap_ok)
        strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == `CBI_STRAP_WAIT)
        bus64_q <= width_s;
      if (wr_ctrl)
        ctrl_q <= cbi_merge(ctrl_q, wb_dat_i, wb_sel_i) & `CBI_CTRL_MASK;
      if (wr_addr)
        addr_reg_q <= cbi_merge(addr_reg_q, wb_dat_i, wb_sel_i);
      if (wr_cmd)
        cmd_q <= wb_dat_i & `CBI_CMD_MASK;
      go_q    <= wr_cmd | (go_q & !(st_q == CBI_S_IDLE && st_d == CBI_S_AREQ));
      // hardware set wins over a software clear in the same cycle
      done_q  <= ev_done | (done_q & !(wr_stat & wb_dat_i[`CBI_STAT_DONE]));
      aperr_q <= (tick_w & !aperr_n_s) | (aperr_q & !(wr_stat & wb_dat_i[`CBI_STAT_APERR]));
      dperr_q <= dbad_w | (dperr_q & !(wr_stat & wb_dat_i[`CBI_STAT_DPERR]));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `CBI_DATA_WORDS; i++)
        data_q[i] <= 32'h0;
    end
    else if (beat_ok & !is_wr)
    begin
      if (bus64_q)
      begin
        data_q[{beat_q[1:0], 1'b0}] <= din_s[31:0];
        data_q[{beat_q[1:0], 1'b1}] <= din_s[63:32];
      end
      else
        data_q[beat_q] <= din_s[31:0];
    end
    else if (wr_data)
      data_q[wb_adr_i[4:2]] <= cbi_merge(data_q[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
  end

  // --------------------------------------------------------------------------
  // pin outputs, low pins reset high
  // --------------------------------------------------------------------------
  logic        br_n_q, ts_n_q, aoe_q, dbr_n_q, doe_q, dperr_n_q, qreq_n_q, sync_q;
  logic        tbst_n_q, wt_n_q, ci_n_q;
  logic [31:0] addr_q;
  logic [3:0]  ap_q;
  logic [4:0]  tt_q;
  logic [2:0]  tsiz_q;
  logic [63:0] dout_q;
  logic [7:0]  dp_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      br_n_q   <= 1'b1;
      ts_n_q   <= 1'b1;
      aoe_q    <= 1'b0;
      dbr_n_q  <= 1'b1;
      doe_q    <= 1'b0;
      dperr_n_q <= 1'b1;
      qreq_n_q <= 1'b1;
      sync_q   <= 1'b0;
      addr_q   <= 32'h0;
      ap_q     <= 4'h0;
      tt_q     <= 5'h0;
      tsiz_q   <= 3'h0;
      tbst_n_q <= 1'b1;
      wt_n_q   <= 1'b1;
      ci_n_q   <= 1'b1;
      dout_q   <= 64'h0;
      dp_q     <= 8'h0;
    end
    else
    begin
      br_n_q    <= (st_d != CBI_S_AREQ);
      ts_n_q    <= (st_d != CBI_S_ATS);
      aoe_q     <= (st_d == CBI_S_ATS) | (st_d == CBI_S_AWAIT);
      dbr_n_q   <= (st_d != CBI_S_DREQ);
      doe_q     <= (st_d == CBI_S_DBEAT) & is_wr;
      if (tick_w)
        dperr_n_q <= !dbad_w;
      qreq_n_q  <= !ctrl_q[`CBI_CTRL_QREQ];
      sync_q    <= tick_w;
      if (st_d == CBI_S_ATS && st_q != CBI_S_ATS)
      begin
        addr_q   <= addr_reg_q;
        ap_q     <= apar_if.par;
        tt_q     <= cmd_q[`CBI_CMD_TT_MSB:`CBI_CMD_TT_LSB];
        tsiz_q   <= (nb_w == `CBI_BEATS_SINGLE) ? sz_w : 3'h0;
        tbst_n_q <= (nb_w == `CBI_BEATS_SINGLE);
        wt_n_q   <= !cmd_q[`CBI_CMD_WT];
        ci_n_q   <= !cmd_q[`CBI_CMD_CI];
      end
      if (st_d == CBI_S_DBEAT)
      begin
        dout_q <= dout_w;
        dp_q   <= opar_if.par;
      end
    end
  end

  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rdat_q;
  assign rsrv_o    = ctrl_q[`CBI_CTRL_RSRV];
  assign tben_o    = ctrl_q[`CBI_CTRL_TBEN];
  assign qreq_n_o  = qreq_n_q;
  assign bus_sync_o = sync_q;
  assign br_n_o    = br_n_q;
  assign transfer_start_strobe_n_o = ts_n_q;
  assign addr_o    = addr_q;
  assign addr_oe_o = aoe_q;
  assign address_parity_bits_o = ap_q;
  assign transfer_type_code_o  = tt_q;
  assign tsiz_o    = tsiz_q;
  assign tbst_n_o  = tbst_n_q;
  assign wt_n_o    = wt_n_q;
  assign ci_n_o    = ci_n_q;
  assign dbr_n_o   = dbr_n_q;
  assign data_o    = dout_q;
  assign data_oe_o = doe_q;
  assign dp_o      = dp_q;
  assign dperr_n_o = dperr_n_q;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_ts_after_grant: assert property ($fell(ts_n_q) |-> !$past(bg_n_s))
    else $error("start strobe without address grant");
  a_retry_rearb: assert property ((tick_w && st_q == CBI_S_AWAIT && !address_retry_n_s) |=> (!br_n_q && ts_n_q))
    else $error("retry did not return to arbitration");
  a_line_beats: assert property ((!ts_n_q && is_line) |-> (nb_w == (bus64_q ? 4'd4 : 4'd8)))
    else $error("line burst beat count wrong");
  a_nc_beats: assert property ((!ts_n_q && !is_line) |-> (nb_w == ((is_dbl && !bus64_q) ? 4'd2 : 4'd1)))
    else $error("noncached beat count wrong");
  a_burst_attr: assert property (!ts_n_q |-> (tbst_n_q == (nb_w == 4'd1) && aoe_q))
    else $error("burst attribute disagrees with beats");
  a_size_narrow: assert property ((!ts_n_q && !bus64_q && tbst_n_q) |-> (tsiz_q inside {3'h1, 3'h2, 3'h3, 3'h4}))
    else $error("narrow bus size out of range");
  a_addr_parity: assert property (!ts_n_q |-> (addr_q == addr_reg_q && ap_q == apar_if.par))
    else $error("address parity mismatch");
  a_last_beat: assert property ((beat_ok && last_w) |=> (st_q == CBI_S_IDLE && !doe_q && done_q))
    else $error("tenure not ended after last beat");
  a_idle_quiet: assert property ((st_q == CBI_S_IDLE) |-> (ts_n_q && br_n_q && dbr_n_q && !aoe_q))
    else $error("bus driven while idle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

endmodule : cbi_bus_if

`default_nettype wire

/* File: logic/cbi_map.svh */
`ifndef CBI_MAP_SVH
`define CBI_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses on the wishbone slave)
// ----------------------------------------------------------------------------
`define CBI_OFF_CTRL        8'h00
`define CBI_OFF_ADDR        8'h04
`define CBI_OFF_CMD         8'h08
`define CBI_OFF_STAT        8'h0c
`define CBI_DATA_PAGE       3'h1
`define CBI_DATA_WORDS      8

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CBI_CTRL_RST        32'h0000_0001
`define CBI_CTRL_RATIO_MSB  3
`define CBI_CTRL_RATIO_LSB  0
`define CBI_CTRL_TBEN       8
`define CBI_CTRL_QREQ       9
`define CBI_CTRL_RSRV       10
`define CBI_CTRL_MASK       32'h0000_070f

// ----------------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------------
`define CBI_CMD_KIND_MSB    2
`define CBI_CMD_KIND_LSB    0
`define CBI_CMD_SIZE_MSB    5
`define CBI_CMD_SIZE_LSB    3
`define CBI_CMD_CI          6
`define CBI_CMD_WT          7
`define CBI_CMD_TT_MSB      12
`define CBI_CMD_TT_LSB      8
`define CBI_CMD_MASK        32'h0000_1fff

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define CBI_STAT_BUSY       0
`define CBI_STAT_DONE       1
`define CBI_STAT_APERR      2
`define CBI_STAT_DPERR      3
`define CBI_STAT_BUS64      4
`define CBI_STAT_QACK       5
`define CBI_STAT_HOLD       6

// ----------------------------------------------------------------------------
// beat counts, sizes and strap wait
// ----------------------------------------------------------------------------
`define CBI_BEATS_LINE32    4'd8
`define CBI_BEATS_LINE64    4'd4
`define CBI_BEATS_DBL32     4'd2
`define CBI_BEATS_SINGLE    4'd1
`define CBI_MAX_BYTES32     3'h4
`define CBI_STRAP_WAIT      2'h2

`endif

/* File: logic/cbi_pkg.sv */
package cbi_pkg;

  typedef enum logic [2:0]
  {
    CBI_K_ADDR = 3'h0,
    CBI_K_SRD  = 3'h1,
    CBI_K_SWR  = 3'h2,
    CBI_K_DRD  = 3'h3,
    CBI_K_DWR  = 3'h4,
    CBI_K_LRD  = 3'h5,
    CBI_K_LWR  = 3'h6,
    CBI_K_RSVD = 3'h7
  } cbi_kind_t;

  typedef enum logic [5:0]
  {
    CBI_S_IDLE  = 6'h01,
    CBI_S_AREQ  = 6'h02,
    CBI_S_ATS   = 6'h04,
    CBI_S_AWAIT = 6'h08,
    CBI_S_DREQ  = 6'h10,
    CBI_S_DBEAT = 6'h20
  } cbi_state_t;

endpackage : cbi_pkg

/* File: logic/cbi_par_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface cbi_par_if #(parameter int NB = 8);
  logic [8*NB-1:0] data;
  logic [NB-1:0]   par;
  modport src (output data, input par);
  modport gen (input data, output par);
endinterface : cbi_par_if

`default_nettype wire

/* File: logic/cbi_par_gen.sv */
`timescale 1ns/1ps
`default_nettype none

module cbi_par_gen #(
  parameter int NB  = 8,
  parameter bit ODD = 1'b1
) (
  cbi_par_if.gen p
);

  // one parity bit per byte lane
  for (genvar g = 0; g < NB; g++)
  begin : g_lane
    assign p.par[g] = (^p.data[8*g +: 8]) ^ ODD;
  end

endmodule : cbi_par_gen

`default_nettype wire

/* File: tb/cbi_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------
// arbiter and memory on the far side of the bus
// ----------------------------------------------
module cbi_bus_model (
  // clock, reset and scenario control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        retry_en_i,
  // from the device
  input  wire logic        br_n_i,
  input  wire logic        ts_n_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  ap_i,
  input  wire logic [7:0]  attr_i,
  input  wire logic        dbr_n_i,
  input  wire logic        doe_i,
  input  wire logic [63:0] wdat_i,
  // to the device
  output logic             bg_n_o,
  output logic             aack_n_o,
  output logic             retry_n_o,
  output logic             dbg_n_o,
  output logic             ta_n_o,
  output logic             drtry_n_o,
  output logic      [63:0] data_o,
  output logic      [7:0]  dp_o,
  // observation
  output int               ts_cnt_o,
  output int               wr_beats_o,
  output int               ap_bad_o,
  output logic      [39:0] ts_lat_o,
  output logic      [63:0] wlast_o
);
  logic [3:0]  acnt;
  logic [3:0]  tcnt;
  logic [2:0]  bc;
  logic        dten;
  logic        rpend;
  logic        dpend;
  logic [3:0]  ap_exp;
  logic [31:0] pv;

  assign pv     = 32'hc0de0000 + 32'(bc);
  // off-beat data is inverted so a stale value never passes for a beat
  assign data_o = ta_n_o ? ~{2{pv}} : {2{pv}};
  for (genvar i = 0; i < 8; i++)
  begin : g_dp
    assign dp_o[i] = ~^data_o[8*i+:8];
  end
  for (genvar i = 0; i < 4; i++)
  begin : g_ap
    assign ap_exp[i] = ~^addr_i[8*i+:8];
  end

  always @(posedge clk_i)
    if (rst_i)
    begin
      {bg_n_o, aack_n_o, retry_n_o, dbg_n_o, ta_n_o, drtry_n_o} <= 6'h3f;
      {acnt, tcnt, bc, dten, rpend, dpend} <= '0;
    end
    else
    begin
      bg_n_o <= br_n_i;
      dbg_n_o <= dbr_n_i;
      {aack_n_o, retry_n_o, ta_n_o, drtry_n_o} <= 4'hf;
      if (acnt != 0)
        acnt <= acnt - 4'h1;
      if (!ts_n_i)
      begin
        ts_cnt_o <= ts_cnt_o + 1;
        ts_lat_o <= {addr_i, attr_i};
        acnt <= 4'(1 + $urandom % 4);
        if (ap_i !== ap_exp)
          ap_bad_o <= ap_bad_o + 1;
      end
      else if (acnt == 1 && retry_en_i && !rpend)
      begin
        retry_n_o <= 1'b0;
        rpend <= 1'b1;
      end
      else if (acnt == 1)
      begin
        aack_n_o <= 1'b0;
        rpend <= 1'b0;
      end
      if (!dbr_n_i)
      begin
        dten <= 1'b1;
        {bc, dpend} <= '0;
        tcnt <= 4'h6;
      end
      else if (dten && tcnt == 1)
      begin
        ta_n_o <= 1'b0;
        {drtry_n_o, dpend} <= {!retry_en_i | dpend, 1'b1};
        tcnt <= 4'(5 + $urandom % 3);
      end
      else if (dten)
        tcnt <= tcnt - 4'h1;
      if (!ta_n_o && drtry_n_o)
        bc <= bc + 3'h1;
      if (!ta_n_o && doe_i)
      begin
        wr_beats_o <= wr_beats_o + 1;
        wlast_o <= wdat_i;
      end
      if (!br_n_i)
        dten <= 1'b0;
    end
endmodule : cbi_bus_model

`default_nettype wire

/* File: tb/test_cpu_system_bus_interface.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cbi_map.svh"

module test_cpu_system_bus_interface;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, width64_i, rty_en, ape_n;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rv;
  logic        wb_ack_o, rsrv_o, tben_o, qreq_n_o, br_n_o, bg_n_i, transfer_start_strobe_n_o;
  logic [31:0] addr_o;
  logic [3:0]  address_parity_bits_o;
  logic [4:0]  transfer_type_code_o;
  logic        tbst_n_o, wt_n_o, ci_n_o, aack_n_i, address_retry_n_i, dbr_n_o, dbg_n_i, data_oe_o, ta_n_i, drtry_n;
  logic [63:0] data_i, data_o, wlast, e;
  logic [7:0]  dp_i;
  logic [39:0] tsl;
  int          ts_cnt, wr_beats, ap_bad, err_total = 0, check_count = 0;
  logic [63:0] q[$];

  cbi_bus_if dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .width64_i, .qack_n_i(1'b1), .tlbsync_n_i(1'b1), .rsrv_o, .tben_o, .qreq_n_o,
    .bus_sync_o(), .br_n_o, .bg_n_i, .transfer_start_strobe_n_o, .addr_o, .addr_oe_o(),
    .address_parity_bits_o, .transfer_type_code_o, .tsiz_o(), .tbst_n_o, .wt_n_o, .ci_n_o, .aack_n_i,
    .address_retry_n_i, .aperr_n_i(ape_n), .dbr_n_o, .dbg_n_i, .data_i, .data_o, .data_oe_o, .dp_i,
    .dp_o(), .dperr_n_o(), .ta_n_i, .drtry_n_i(drtry_n));

  cbi_bus_model mdl_u (.clk_i, .rst_i, .retry_en_i(rty_en), .br_n_i(br_n_o), .ts_n_i(transfer_start_strobe_n_o),
    .addr_i(addr_o), .ap_i(address_parity_bits_o), .attr_i({transfer_type_code_o, tbst_n_o, wt_n_o, ci_n_o}),
    .dbr_n_i(dbr_n_o), .doe_i(data_oe_o), .wdat_i(data_o), .bg_n_o(bg_n_i), .aack_n_o(aack_n_i),
    .retry_n_o(address_retry_n_i), .dbg_n_o(dbg_n_i), .ta_n_o(ta_n_i), .data_o(data_i), .dp_o(dp_i),
    .drtry_n_o(drtry_n), .ts_cnt_o(ts_cnt), .wr_beats_o(wr_beats), .ap_bad_o(ap_bad), .ts_lat_o(tsl), .wlast_o(wlast));

  // ----------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic ck(input string n, input logic [63:0] x, input logic [63:0] s);
    check_count++;
    if (s !== x)
    begin
      $display("ERROR %s expected %h seen %h", n, x, s);
      err_total++;
    end
  endtask : ck

  // reads note {mask, expected}; the monitor below does the compare
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    output logic [31:0] r);
    @(posedge clk_i);
    if (!w)
      q.push_back({m, d});
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb

  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      e = q.pop_front();
      ck("wb read", e[31:0] & e[63:32], wb_dat_o & e[63:32]);
    end

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // hang guard: the tests need well under 10000 cycles
  initial
  begin
    #1000000;
    err_total++;
    print_verdict();
  end

  initial
  begin
    logic [31:0] a, c, wd [8];
    int          nb, lim, ts0, wb0;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, width64_i, rty_en, ape_n} = 7'b1000001;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'hf, 32'h0};
    a = $urandom(32'hc26a);
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk_i);
      {rst_i, width64_i} <= {1'b1, m[0]};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      wb(0, `CBI_OFF_CTRL, 32'h1, '1, rv);
      wb(0, `CBI_OFF_STAT, {27'h0, m[0], 4'h0}, 32'h1f, rv);
      wb(0, 8'h10, 32'h0, '1, rv);
      wb(1, `CBI_OFF_CTRL, 32'h701, 0, rv);
      wb(0, `CBI_OFF_CTRL, 32'h701, 32'h70f, rv);
      ck("state outs", 3'b110, {tben_o, rsrv_o, qreq_n_o});
      wb(1, `CBI_OFF_CTRL, 32'h1, 0, rv);
      for (int k = 0; k < 8; k++)
      begin
        a = $urandom & 32'hffff_ffe0;
        for (int w = 0; w < 8; w++)
        begin
          wd[w] = $urandom;
          wb(1, 8'h20 + 8'(4 * w), wd[w], 0, rv);
        end
        wb(1, `CBI_OFF_ADDR, a, 0, rv);
        c = {19'h0, 5'($urandom), 2'($urandom), 3'h4, 3'(k)};
        nb = (k == 0 || k == 7) ? 0 : (k < 3) ? 1 : (k < 5) ? (m ? 1 : 2) : (m ? 4 : 8);
        {ts0, wb0, lim} = {ts_cnt, wr_beats, 32'd0};
        rty_en <= (k inside {5, 7});
        ape_n <= (k != 0);
        wb(1, `CBI_OFF_CMD, c, 0, rv);
        do wb(0, `CBI_OFF_STAT, 0, 0, rv); while (rv[1] !== 1'b1 && ++lim < 300);
        ck("done", 1, rv[1]);
        wb(1, `CBI_OFF_STAT, 32'h6, 0, rv);
        wb(0, `CBI_OFF_STAT, {29'h0, k == 0, 2'h0}, 32'hf, rv);
        ck("ts count", (k inside {5, 7}) ? 2 : 1, ts_cnt - ts0);
        ck("attrs", {a, c[12:8], nb < 2, ~c[7:6]}, tsl);
        if (k inside {2, 4, 6})
          ck("write beats", nb, wr_beats - wb0);
        if (k == 6)
          ck("last write", 1, wlast[31:0] === wd[7] || wlast[63:32] === wd[7]);
        if (k inside {1, 3, 5})
          for (int w = 0; w < 8; w++)
            wb(0, 8'h20 + 8'(4 * w), (w < (k == 1 ? 1 : nb * (m + 1))) ? 32'hc0de0000 + 32'(m ? w / 2 : w) :
               wd[w], (k == 1 && m && w == 1) ? 32'h0 : 32'hffff_ffff, rv);
      end
    end
    ck("addr parity", 0, ap_bad);
    print_verdict();
  end
endmodule : test_cpu_system_bus_interface

`default_nettype wire
